// >>> hdl/flight_status_pkg.sv
// constants for the flight-time status and result register block
// assumes a 25 MHz core clock and a host serial port sampled by that clock
package flight_status_pkg;
  localparam int SYNC_STAGES = 3;
  // idle pin levels {sel_n, clk, din}: matching them avoids a false clock edge after reset
  localparam logic [2:0] PINS_RESET = 3'h4;
  localparam logic [7:0] OPC_EVENT_FLAGS = 8'hfe;
  localparam logic [7:0] OPC_RATIOS = 8'hc4;
  localparam logic [7:0] OPC_HIT1_WHOLE = 8'hc5;
  localparam logic [7:0] OPC_HIT1_PART = 8'hc6;
  localparam int BIT_EXPIRY = 15;
  localparam int BIT_FLIGHT = 12;
  localparam int BIT_THERMAL = 11;
  localparam int BIT_TRIM = 6;
  localparam int BIT_SETUP = 3;
  localparam int BIT_POWERUP = 2;
  localparam logic [15:0] FLAGS_USED_MASK = 16'h984c;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [7:0] RATIO_MAX = 8'hff;
  localparam logic [14:0] WHOLE_MAX = 15'h7fff;
  localparam logic [3:0] OPCODE_BITS = 4'h8;
  localparam logic [4:0] DATA_BITS = 5'h10;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OPCODE = 3'b010,
    ST_DATA = 3'b100
  } port_state_type;
endpackage

// >>> hdl/flight_time_status_results.sv
// event flag register and upstream result registers behind the host serial port
// assumes measurement engines give one-cycle done pulses on clk; port pins are asynchronous
// How it works
// - flight-time command completion sets event bit 12
// - temperature command completion sets event bit 11
// - calibration completion sets bit 6 only when host issued the command
// - initialize command completion sets event bit 3
// - successful power-on sets event bit 2
// - serial port ignores the host until power-up flag has been set
// - result registers are read-only, zero after reset, writes ignored
// - ratio register high byte holds first over second pulse width, 1.7 format
// - ratio register low byte holds second width over half launch period
// - each ratio field saturates at 1.9921875
// - first hit whole part is 15-bit count of reference periods
// - first hit fraction is 16-bit fraction of one reference period
// - missing measurement within its timeout sets event bit 15
`timescale 1ns/1ps
module flight_time_status_results (
  input wire logic clk,
  input wire logic resetn,
  input wire logic port_sel_n,
  input wire logic port_clk,
  input wire logic port_din,
  output logic port_dout,
  output logic port_dout_en,
  input wire logic flight_done,
  input wire logic thermal_done,
  input wire logic trim_done,
  input wire logic trim_by_host,
  input wire logic setup_done,
  input wire logic powerup_done,
  input wire logic expiry_event,
  input wire logic result_load,
  input wire logic [8:0] ratio_first_raw,
  input wire logic [8:0] ratio_second_raw,
  input wire logic [15:0] hit_whole_raw,
  input wire logic [15:0] hit_part_raw
);
  import flight_status_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // a change counts only once stages two and three agree, which rejects one-sample glitches
  logic [2:0] pins_in;
  logic [2:0] sync1_r, sync2_r, sync3_r, filt_r, filt_nxt, filt_old_r;
  assign pins_in = {port_sel_n, port_clk, port_din};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_comb begin
        filt_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : filt_r[gi];
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= PINS_RESET;
      sync2_r <= PINS_RESET;
      sync3_r <= PINS_RESET;
      filt_r <= PINS_RESET;
      filt_old_r <= PINS_RESET;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
      filt_old_r <= filt_r;
    end
  end
  logic sel_act, clk_rise, clk_fall;
  assign sel_act = !filt_r[2];
  assign clk_rise = filt_r[1] && !filt_old_r[1];
  assign clk_fall = !filt_r[1] && filt_old_r[1];

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  logic [15:0] ratios_r, ratios_nxt, whole_r, whole_nxt, part_r, part_nxt;
  always_comb begin
    ratios_nxt = ratios_r;
    whole_nxt = whole_r;
    part_nxt = part_r;
    // the port has no write path, so only the engine load changes these
    if (result_load) begin
      ratios_nxt[15:8] = ratio_first_raw[8] ? RATIO_MAX : ratio_first_raw[7:0];
      ratios_nxt[7:0] = ratio_second_raw[8] ? RATIO_MAX : ratio_second_raw[7:0];
      whole_nxt = {1'b0, hit_whole_raw[15] ? WHOLE_MAX : hit_whole_raw[14:0]};
      part_nxt = hit_part_raw;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ratios_r <= RESULT_RESET;
      whole_r <= RESULT_RESET;
      part_r <= RESULT_RESET;
    end else begin
      ratios_r <= ratios_nxt;
      whole_r <= whole_nxt;
      part_r <= part_nxt;
    end
  end

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  logic [15:0] flags_r, flags_nxt, flag_set;
  logic powered_r, powered_nxt, flags_clear;
  always_comb begin
    flag_set = 16'h0000;
    flag_set[BIT_EXPIRY] = expiry_event;
    flag_set[BIT_FLIGHT] = flight_done;
    flag_set[BIT_THERMAL] = thermal_done;
    flag_set[BIT_TRIM] = trim_done && trim_by_host;
    flag_set[BIT_SETUP] = setup_done;
    flag_set[BIT_POWERUP] = powerup_done;
    // set wins over the read clear so a coincident event is not lost
    flags_nxt = ((flags_clear ? 16'h0000 : flags_r) | flag_set) & FLAGS_USED_MASK;
    powered_nxt = powered_r || powerup_done;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_r <= FLAGS_RESET;
      powered_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      powered_r <= powered_nxt;
    end
  end

  // ----------------------------------------
  // serial port: 8-bit opcode in, 16-bit word out msb first
  // ----------------------------------------
  port_state_type state_r, state_nxt;
  logic [7:0] opc_r, opc_nxt, opc_full;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic dout_r, dout_nxt, douten_r, douten_nxt;
  assign opc_full = {opc_r[6:0], filt_r[0]};
  always_comb begin
    state_nxt = state_r;
    opc_nxt = opc_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    dout_nxt = dout_r;
    douten_nxt = 1'b0;
    flags_clear = 1'b0;
    // until power-up completes, selection is ignored and the output stays undriven
    if (!sel_act || !powered_r) begin
      state_nxt = ST_IDLE;
      cnt_nxt = 5'h00;
      dout_nxt = 1'b0;
    end else begin
      douten_nxt = 1'b1;
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_OPCODE;
          cnt_nxt = 5'h00;
        end
        ST_OPCODE: begin
          if (clk_rise) begin
            opc_nxt = opc_full;
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r[3:0] == OPCODE_BITS - 4'h1) begin
              state_nxt = ST_DATA;
              cnt_nxt = 5'h00;
              unique case (opc_full)
                OPC_EVENT_FLAGS: begin
                  shift_nxt = flags_r;
                  flags_clear = 1'b1;
                end
                OPC_RATIOS: shift_nxt = ratios_r;
                OPC_HIT1_WHOLE: shift_nxt = whole_r;
                OPC_HIT1_PART: shift_nxt = part_r;
                default: shift_nxt = 16'h0000;
              endcase
            end
          end
        end
        ST_DATA: begin
          if (clk_fall && cnt_r != DATA_BITS) begin
            dout_nxt = shift_r[15];
            shift_nxt = {shift_r[14:0], 1'b0};
            cnt_nxt = cnt_r + 5'h01;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      opc_r <= 8'h00;
      cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      dout_r <= 1'b0;
      douten_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      opc_r <= opc_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      dout_r <= dout_nxt;
      douten_r <= douten_nxt;
    end
  end
  assign port_dout = dout_r;
  assign port_dout_en = douten_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_flight_flag_set: assert property (flight_done |=> flags_r[BIT_FLIGHT]) else $error("flight flag not set");
  chk_thermal_flag_set: assert property (thermal_done |=> flags_r[BIT_THERMAL]) else $error("thermal flag not set");
  chk_trim_auto_ignored: assert property (trim_done && !trim_by_host && !flags_r[BIT_TRIM]
    |=> !flags_r[BIT_TRIM]) else $error("automatic trim set flag");
  chk_setup_flag_set: assert property (setup_done |=> flags_r[BIT_SETUP]) else $error("setup flag not set");
  chk_powerup_flag_set: assert property (powerup_done |=> flags_r[BIT_POWERUP] && powered_r)
    else $error("powerup flag not set");
  chk_port_quiet_early: assert property (!powered_r |=> !port_dout_en && state_r == ST_IDLE)
    else $error("port active before power-up");
  chk_results_stable: assert property (!result_load |=> $stable(ratios_r) && $stable(whole_r) && $stable(part_r))
    else $error("result changed without load");
  chk_ratio_saturate: assert property (result_load && ratio_first_raw[8] |=> ratios_r[15:8] == RATIO_MAX)
    else $error("ratio not saturated");
  chk_expiry_flag_set: assert property (expiry_event |=> flags_r[BIT_EXPIRY]) else $error("expiry flag not set");
  chk_read_clears: assert property (flags_clear && flag_set == 16'h0000 |=> flags_r == 16'h0000)
    else $error("read did not clear flags");
  chk_reserved_zero: assert property ((flags_r & ~FLAGS_USED_MASK) == 16'h0000) else $error("reserved bit set");
  chk_whole_msb_zero: assert property (!whole_r[15]) else $error("whole msb set");
endmodule

// >>> tb/host_port.sv
// host model: serial port master, mode 0, one read frame per call
// assumes the device samples these pins on its own clock
`timescale 1ns/1ps
module host_port (
  output logic port_sel_n,
  output logic port_clk,
  output logic port_din,
  input wire logic port_dout,
  input wire logic port_dout_en
);
  logic en_seen = 1'b0;
  initial begin
    port_sel_n = 1'b1;
    port_clk = 1'b0;
    port_din = 1'b0;
  end
  // clock stands low outside frames; data is sampled late in the high phase
  task automatic xfer(input logic [23:0] tx, output logic [15:0] rx);
    en_seen = 1'b0;
    port_sel_n = 1'b0;
    #160;
    for (int i = 23; i >= 0; i--) begin
      port_din = tx[i];
      #160 port_clk = 1'b1;
      #150 if (i < 16) rx[i] = port_dout;
      en_seen = en_seen | port_dout_en;
      #10 port_clk = 1'b0;
    end
    #160 port_sel_n = 1'b1;
    // released line: show the inverse, not the last value
    port_din = ~port_din;
    #200;
  endtask
endmodule

// >>> tb/tb_flight_time_status_results.sv
// bench for the flight-time status and result registers
// assumes a 25 MHz clk and host_port as the serial master
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_flight_time_status_results;
  import flight_status_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic flight = 1'b0, thermal = 1'b0, trim = 1'b0, by_host = 1'b0;
  logic setup = 1'b0, pwr = 1'b0, expiry = 1'b0, load = 1'b0;
  logic [8:0] r1 = 9'h000, r2 = 9'h000;
  logic [15:0] whole = 16'h0000, part = 16'h0000, rd;
  wire sel_n, pclk, din, dout, dout_en;
  int mismatches = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  flight_time_status_results i_dut (.clk(clk), .resetn(resetn), .port_sel_n(sel_n), .port_clk(pclk),
    .port_din(din), .port_dout(dout), .port_dout_en(dout_en), .flight_done(flight), .thermal_done(thermal),
    .trim_done(trim), .trim_by_host(by_host), .setup_done(setup), .powerup_done(pwr), .expiry_event(expiry),
    .result_load(load), .ratio_first_raw(r1), .ratio_second_raw(r2), .hit_whole_raw(whole), .hit_part_raw(part));
  host_port i_host (.port_sel_n(sel_n), .port_clk(pclk), .port_din(din), .port_dout(dout),
    .port_dout_en(dout_en));
  // one-cycle pulse on the engine inputs
  task automatic ev(input logic [7:0] v);
    @(posedge clk) #1 {flight, thermal, trim, by_host, setup, pwr, expiry, load} = v;
    @(posedge clk) #1 {flight, thermal, trim, by_host, setup, pwr, expiry, load} = 8'h00;
  endtask
  task automatic rdr(input logic [7:0] op, input logic [15:0] wr);
    i_host.xfer({op, wr}, rd);
  endtask
  task automatic test_power;
    rdr(OPC_EVENT_FLAGS, 16'h0000);
    `CHK(i_host.en_seen, 1'b0)
    ev(8'h04);
    rdr(OPC_EVENT_FLAGS, 16'h0000);
    `CHK(rd, 16'h0004)
    `CHK(i_host.en_seen, 1'b1)
    rdr(OPC_EVENT_FLAGS, 16'h0000);
    `CHK(rd, 16'h0000)
    $display("test_power done");
  endtask
  task automatic test_flags;
    logic [7:0] evs [6] = '{8'h80, 8'h40, 8'h30, 8'h08, 8'h02, 8'h20};
    logic [15:0] exf [6] = '{16'h1000, 16'h0800, 16'h0040, 16'h0008, 16'h8000, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      ev(evs[i]);
      rdr(OPC_EVENT_FLAGS, 16'hffff);
      `CHK(rd, exf[i])
    end
    // back to back events pile up until the one read
    for (int i = 0; i < 5; i++) ev(evs[i]);
    rdr(OPC_EVENT_FLAGS, 16'h0000);
    `CHK(rd, 16'h9848)
    // an unknown opcode answers zero and must leave the flags alone
    ev(8'h80);
    rdr(8'h5a, 16'h0000);
    `CHK(rd, 16'h0000)
    rdr(OPC_EVENT_FLAGS, 16'h0000);
    `CHK(rd, 16'h1000)
    $display("test_flags done");
  endtask
  task automatic load_chk(input logic [8:0] a, input logic [8:0] b, input logic [15:0] w, input logic [15:0] p,
    input logic [15:0] e4, input logic [15:0] e5);
    @(posedge clk) #1 {r1, r2, whole, part} = {a, b, w, p};
    ev(8'h01);
    rdr(OPC_RATIOS, 16'h0000);
    `CHK(rd, e4)
    rdr(OPC_HIT1_WHOLE, 16'h0000);
    `CHK(rd, e5)
    rdr(OPC_HIT1_PART, ~p);
    rdr(OPC_HIT1_PART, 16'h0000);
    `CHK(rd, p)
  endtask
  task automatic test_results;
    logic [7:0] ops [3] = '{OPC_RATIOS, OPC_HIT1_WHOLE, OPC_HIT1_PART};
    for (int i = 0; i < 3; i++) begin
      rdr(ops[i], 16'hffff);
      `CHK(rd, RESULT_RESET)
    end
    load_chk(9'h0ab, 9'h1ff, 16'hffff, 16'h1234, 16'habff, 16'h7fff);
    load_chk(9'h100, 9'h05a, 16'h1234, 16'hffff, 16'hff5a, 16'h1234);
    $display("test_results done");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    test_power;
    test_flags;
    test_results;
    end_of_test;
  end
endmodule
